// ### rtl/asrc_ctrl.sv
`include "asrc_params.svh"
module asrc_ctrl (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              req_valid_in,
    input  wire asrc_pkg::asrc_req_t req_in,
    output logic                   req_ready_out,
    output logic                   rsp_valid_out,
    output asrc_pkg::asrc_rsp_t    rsp_out,
    input  wire logic              retain_req_in,
    output logic                   retained_out,
    output asrc_pkg::asrc_ctl_t    mem_ctl_out,
    output logic [15:0]            mem_data_out,
    output logic [15:0]            mem_data_oe_out,
    input  wire logic [15:0]       mem_data_in,
    input  wire logic              mem_err_in
);
    import asrc_pkg::*;
    localparam logic [`ASRC_CNT_W-1:0] WR_N  = `ASRC_CNT_W'(`ASRC_WR_CYC);
    localparam logic [`ASRC_CNT_W-1:0] RD_N  = `ASRC_CNT_W'(`ASRC_RD_CYC);
    localparam logic [`ASRC_CNT_W-1:0] TU_N  = `ASRC_CNT_W'(`ASRC_TURN_CYC);
    localparam logic [`ASRC_CNT_W-1:0] REC_N = `ASRC_CNT_W'(`ASRC_REC_CYC);

    asrc_state_t          state_q;
    logic [`ASRC_CNT_W-1:0] cnt_q;
    logic                 retain_q;
    logic [16:0]          pin_s;

    // Data and flag pins come from outside the clock domain.
    asrc_sync #(.W(17)) u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({mem_err_in, mem_data_in}),
        .q_out    (pin_s)
    );

    wire logic take = (state_q == ASRC_IDLE) && req_valid_in && !retain_req_in && (req_in.byte_en != 2'b00);
    wire logic last = (cnt_q == '0);

    // Sequencer: requests are taken only from idle, and every access is followed by one
    // turnaround cycle so that our data drivers and the memory's never overlap.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ASRC_IDLE;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                ASRC_IDLE: begin
                    if (retain_req_in) begin
                        state_q <= ASRC_RETAIN; // [R16]
                        cnt_q   <= REC_N - 1'b1;
                    end else if (take) begin
                        state_q <= req_in.write ? ASRC_WRITE : ASRC_READ;
                        cnt_q   <= req_in.write ? WR_N - 1'b1 : RD_N - 1'b1; // [R21]
                    end
                end
                ASRC_WRITE, ASRC_READ: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (last) begin
                        state_q <= ASRC_TURN;
                        cnt_q   <= TU_N - 1'b1;
                    end
                end
                ASRC_TURN: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (last) begin
                        state_q <= ASRC_IDLE;
                    end
                end
                ASRC_RETAIN: begin
                    if (retain_req_in) begin
                        cnt_q <= REC_N - 1'b1;
                    end else if (last) begin
                        state_q <= ASRC_IDLE; // [R16]
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: state_q <= ASRC_IDLE;
            endcase
        end
    end

    // Pins: the controls an access uses go low together and all rise together, so the write
    // window equals the strobe width and the address is held throughout.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_ctl_out     <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_strobe_n: 1'b1,
                                 upper_byte_sel_n: 1'b1, lower_byte_sel_n: 1'b1, addr: '0};
            mem_data_out    <= '0;
            mem_data_oe_out <= '0;
        end else if (take) begin
            mem_ctl_out.chip_sel_n       <= 1'b0;                   // [R1]
            mem_ctl_out.wr_strobe_n      <= !req_in.write;           // [R14]
            mem_ctl_out.out_en_n         <= req_in.write;            // [R6]
            mem_ctl_out.upper_byte_sel_n <= !req_in.byte_en[1];      // [R18]
            mem_ctl_out.lower_byte_sel_n <= !req_in.byte_en[0];
            mem_ctl_out.addr             <= req_in.addr;             // [R15] [R5]
            mem_data_out                 <= req_in.wdata;            // [R3]
            mem_data_oe_out <= req_in.write ? {{8{req_in.byte_en[1]}}, {8{req_in.byte_en[0]}}} : 16'h0000;
        end else if ((state_q == ASRC_WRITE || state_q == ASRC_READ) && last) begin
            mem_ctl_out.chip_sel_n       <= 1'b1;                   // [R2] [R4]
            mem_ctl_out.wr_strobe_n      <= 1'b1;
            mem_ctl_out.out_en_n         <= 1'b1;
            mem_ctl_out.upper_byte_sel_n <= 1'b1;
            mem_ctl_out.lower_byte_sel_n <= 1'b1;
        end else if (state_q == ASRC_TURN && cnt_q == TU_N - 1'b1) begin
            mem_data_oe_out <= '0; // Data released one cycle after write end: a cycle of hold where none is needed.
        end
    end

    // The pins settle one access time after the controls fall, so the first good value is
    // the one that the first synchroniser stage takes two edges into the read. It reaches
    // the second stage at the end of the read and is captured one edge later, which is
    // why the result trails the release of the controls by one cycle.
    logic [1:0] be_q;
    logic       rd_done_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            be_q          <= '0;
            rd_done_q     <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_out       <= '0;
        end else begin
            if (take) begin
                be_q <= req_in.byte_en;
            end
            rd_done_q     <= (state_q == ASRC_READ) && last; // [R21]
            rsp_valid_out <= rd_done_q; // [R8] [R21]
            if (rd_done_q) begin
                rsp_out.rdata <= pin_s[15:0] & {{8{be_q[1]}}, {8{be_q[0]}}}; // [R18]
                rsp_out.err   <= pin_s[16]; // [R17]
            end
        end
    end

    // Ready is a registered view of idleness; a request held while busy simply waits.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_ready_out <= 1'b0;
            retained_out  <= 1'b0;
            retain_q      <= 1'b0;
        end else begin
            req_ready_out <= (state_q == ASRC_IDLE) && !take && !retain_req_in;
            retain_q      <= retain_req_in;
            retained_out  <= (state_q == ASRC_RETAIN) && retain_q; // [R16]
        end
    end

    // Pin checks. The properties watch the registered pins, which change on the same edge as the state.
    sequence s_wr_start;
        (state_q == ASRC_IDLE) && take && req_in.write;
    endsequence
    sequence s_wr_low;
        !mem_ctl_out.wr_strobe_n && !mem_ctl_out.chip_sel_n;
    endsequence

    AST_WR_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R4]
        s_wr_start |=> s_wr_low [*2] ##1 mem_ctl_out.wr_strobe_n)
        else $error("Write strobe width wrong.");
    AST_WR_ALL_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
        !mem_ctl_out.wr_strobe_n |-> !mem_ctl_out.chip_sel_n &&
        !(mem_ctl_out.upper_byte_sel_n && mem_ctl_out.lower_byte_sel_n))
        else $error("Write strobe without select.");
    AST_DATA_SETUP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
        $rose(mem_ctl_out.wr_strobe_n) |-> $stable(mem_data_out) && $past(mem_data_oe_out) != 16'h0000)
        else $error("Write data not set up.");
    AST_ADDR_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R5]
        !mem_ctl_out.chip_sel_n && !$rose(mem_ctl_out.chip_sel_n) && !$fell(mem_ctl_out.chip_sel_n)
        |-> $stable(mem_ctl_out.addr))
        else $error("Address moved during access.");
    AST_RD_STROBE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R14]
        !mem_ctl_out.out_en_n |-> mem_ctl_out.wr_strobe_n && mem_data_oe_out == 16'h0000)
        else $error("Read with strobe or drive.");
    AST_RD_SAMPLE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R21]
        $fell(mem_ctl_out.out_en_n) |-> !rsp_valid_out [*4] ##1 rsp_valid_out)
        else $error("Read sampled at wrong time.");
    AST_RETAIN_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R16]
        $fell(retain_q) |-> mem_ctl_out.chip_sel_n [*2])
        else $error("Access during retention recovery.");
    AST_NO_CONTEND: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R20]
        $rose(mem_ctl_out.out_en_n) |-> mem_ctl_out.chip_sel_n ##1 (mem_data_oe_out == 16'h0000))
        else $error("Drive after read too soon.");

    // Read window: the controls fall together and stay low for the whole access time.
    sequence s_rd_start;
        (state_q == ASRC_IDLE) && take && !req_in.write;
    endsequence
    sequence s_rd_low;
        !mem_ctl_out.out_en_n && !mem_ctl_out.chip_sel_n && mem_ctl_out.wr_strobe_n;
    endsequence

    AST_RD_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R21]
        s_rd_start |=> s_rd_low [*3] ##1 mem_ctl_out.out_en_n)
        else $error("Read window length wrong.");

    AST_RD_LANES: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R14]
        !mem_ctl_out.out_en_n |-> !mem_ctl_out.chip_sel_n &&
        !(mem_ctl_out.upper_byte_sel_n && mem_ctl_out.lower_byte_sel_n))
        else $error("Read without select or lane.");

    // A write must end on all controls at once, so no single edge can cut it short.
    AST_WR_END_ALL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
        $rose(mem_ctl_out.wr_strobe_n) |-> mem_ctl_out.chip_sel_n && mem_ctl_out.upper_byte_sel_n &&
        mem_ctl_out.lower_byte_sel_n)
        else $error("Write not ended by all controls.");

    AST_DATA_RELEASE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
        $rose(mem_ctl_out.wr_strobe_n) |-> (mem_data_oe_out != 16'h0000) ##1 (mem_data_oe_out == 16'h0000))
        else $error("Write data released at wrong time.");

    AST_WR_ADDR_END: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R5]
        $rose(mem_ctl_out.chip_sel_n) |-> $stable(mem_ctl_out.addr))
        else $error("Address moved at access end.");

    // Leaving retention must not select the memory in the same cycle.
    AST_RECOVER_GAP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R16]
        $fell(retained_out) |-> mem_ctl_out.chip_sel_n)
        else $error("Access started while still retained.");

    AST_RSP_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R8]
        rsp_valid_out |=> !rsp_valid_out)
        else $error("Read result longer than one cycle.");
endmodule

// ### rtl/asrc_params.svh
// Functional notes
// R1: A write needs write strobe, chip select and a byte select low together.
// R2: A write ends at the first rising control edge; setup counts from it.
// R3: Write data stands 5 or 8 ns before the write ends; no hold.
// R4: Address, select, byte select and strobe lead write end by 7 or 12 ns.
// R5: Address may change exactly at write start and write end.
// R6: A strobe write with output enable low lasts setup plus float time.
// R7: Memory floats data 5 or 8 ns after strobe falls; redrives 3 ns after rise.
// R8: Read data and flag valid 10 or 15 ns after address; same cycle time.
// R9: Memory holds old data and flag 3 ns after an address change.
// R10: Data and flag valid 10 or 15 ns after select falls; drive from 3 ns.
// R11: Data and flag valid 4.5 or 8 ns after output enable falls.
// R12: Lane valid 4.5 or 8 ns after select falls; floats within 6 or 8.
// R13: Standby within 10 or 15 ns of deselect; power-up immediate on select.
// R14: Address-paced reads keep select, output enable, byte select low, strobe high.
// R15: For enable-paced reads the address is valid by select falling.
// R16: Retention: deselect first, then stay deselected 10 or 15 ns before access.
// R17: Error flag is 1 for corrected read, 0 clean, floats otherwise.
// R18: Lower select gates bits 0-7, upper gates 8-15; unselected lanes float.
// R19: Corrected errors are not written back; only bus data is corrected.
// R20: Data pins float when select, output enable or byte selects are high.
// R21: Round minimum intervals up to clock periods; sample after maximum access delay.
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH
`define ASRC_CLK_PS        10000
// Slow-grade figures in picoseconds, covering both grades.
`define ASRC_T_PWE_PS      12000
`define ASRC_T_SD_PS       8000
`define ASRC_T_HZWE_PS     8000
`define ASRC_T_AA_PS       15000
`define ASRC_T_RC_PS       15000
`define ASRC_T_HZ_PS       8000
`define ASRC_T_R_PS        15000
`define ASRC_CEIL(t)       (((t) + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS)
`define ASRC_WR_CYC        `ASRC_CEIL(`ASRC_T_PWE_PS + `ASRC_T_HZWE_PS)
`define ASRC_RD_CYC        (`ASRC_CEIL(`ASRC_T_AA_PS) + 1)
`define ASRC_TURN_CYC      `ASRC_CEIL(`ASRC_T_HZ_PS)
`define ASRC_REC_CYC       `ASRC_CEIL(`ASRC_T_R_PS)
`define ASRC_CNT_W         4
`endif

// ### rtl/asrc_pkg.sv
package asrc_pkg;
    typedef struct packed {
        logic        write;
        logic [1:0]  byte_en;
        logic [17:0] addr;
        logic [15:0] wdata;
    } asrc_req_t;
    typedef struct packed {
        logic [15:0] rdata;
        logic        err;
    } asrc_rsp_t;
    typedef struct packed {
        logic        chip_sel_n;
        logic        out_en_n;
        logic        wr_strobe_n;
        logic        upper_byte_sel_n;
        logic        lower_byte_sel_n;
        logic [17:0] addr;
    } asrc_ctl_t;
    typedef enum logic [2:0] {ASRC_IDLE, ASRC_WRITE, ASRC_READ, ASRC_TURN, ASRC_RETAIN} asrc_state_t;
endpackage

// ### rtl/asrc_sync.sv
module asrc_sync #(
    parameter int W = 17
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] s1_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q  <= '0;
            q_out <= '0;
        end else begin
            s1_q  <= d_in;
            q_out <= s1_q;
        end
    end
endmodule

// ### tb/asrc_sram_model.sv
module asrc_sram_model (
    input  wire logic                clk_in,
    input  wire asrc_pkg::asrc_ctl_t ctl_in,
    input  wire logic [15:0] data_in,
    input  wire logic [17:0] err_addr_in,
    input  wire logic [4:0]  delay_ns_in,
    output logic      [15:0] data_out,
    output logic             err_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import asrc_pkg::*;
    logic [15:0] mem [logic [17:0]];
    logic [15:0] float_q = 16'h0000;
    logic [15:0] w_data, rd_val, stored;
    logic [17:0] w_addr;
    logic [1:0]  w_lane, rd_lane;
    logic        wr_on, rd_err;
    assign wr_on = !ctl_in.chip_sel_n && !ctl_in.wr_strobe_n &&
                   !(ctl_in.upper_byte_sel_n && ctl_in.lower_byte_sel_n);
    // Released pins show a pattern that moves every cycle, never the last value.
    always @(posedge clk_in) float_q <= float_q + 16'h1357;
    always @* if (wr_on) begin
        w_addr = ctl_in.addr;
        w_lane = ~{ctl_in.upper_byte_sel_n, ctl_in.lower_byte_sel_n};
        w_data = data_in;
    end
    always @(negedge wr_on) begin
        if (w_lane != 2'b00) begin
            if (!mem.exists(w_addr)) mem[w_addr] = 16'h0000;
            if (w_lane[0]) mem[w_addr][7:0] = w_data[7:0];
            if (w_lane[1]) mem[w_addr][15:8] = w_data[15:8];
        end
    end
    assign rd_lane = (!ctl_in.chip_sel_n && !ctl_in.out_en_n && ctl_in.wr_strobe_n) ?
                     ~{ctl_in.upper_byte_sel_n, ctl_in.lower_byte_sel_n} : 2'b00;
    // Reads only deliver corrected data; the stored word is left as it is.
    always @* begin
        stored = mem.exists(ctl_in.addr) ? mem[ctl_in.addr] : 16'h0000;
        rd_val = float_q;
        if (rd_lane[0]) rd_val[7:0] = stored[7:0];
        if (rd_lane[1]) rd_val[15:8] = stored[15:8];
        rd_err = (rd_lane != 2'b00) ? (ctl_in.addr == err_addr_in) : float_q[0];
    end
    always @(rd_val, rd_err) begin
        data_out <= #(delay_ns_in) rd_val;
        err_out <= #(delay_ns_in) rd_err;
    end
endmodule

// ### tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import asrc_pkg::*;
    logic clk_in, rst_n_in, req_valid_in, retain_req_in, req_ready_out, rsp_valid_out, retained_out, mem_err_in;
    asrc_req_t   req_in;
    asrc_rsp_t   rsp_out;
    asrc_ctl_t   mem_ctl_out;
    logic [15:0] mem_data_out, mem_data_oe_out, mem_data_in, mdl_q, bus;
    logic [17:0] err_addr, adr [12];
    logic [4:0]  delay_ns;
    int          fail_count, total_checks;
    asrc_rsp_t   exp_q [$];
    logic [15:0] shadow [logic [17:0]];
    assign bus = (mem_data_oe_out & mem_data_out) | (~mem_data_oe_out & mdl_q);
    asrc_ctrl dut_u (.clk_in, .rst_n_in, .req_valid_in, .req_in, .req_ready_out, .rsp_valid_out, .rsp_out,
        .retain_req_in, .retained_out, .mem_ctl_out, .mem_data_out, .mem_data_oe_out, .mem_data_in(bus),
        .mem_err_in);
    asrc_sram_model mem_u (.clk_in(clk_in), .ctl_in(mem_ctl_out), .data_in(bus), .err_addr_in(err_addr),
        .delay_ns_in(delay_ns), .data_out(mdl_q), .err_out(mem_err_in));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic bad(string m);
        $display("BAD %0t %s", $time, m);
        fail_count++;
    endtask
    task automatic check_rsp(asrc_rsp_t e);
        total_checks++;
        if (rsp_out !== e) bad("read result differs");
    endtask
    task automatic check_bit(logic a, logic e, string m);
        total_checks++;
        if (a !== e) bad(m);
    endtask
    task automatic access(logic wr, logic [1:0] be, logic [17:0] a, logic [15:0] d);
        int n;
        asrc_rsp_t e;
        n = 0;
        while (req_ready_out !== 1'b1 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 50) bad("ready never came");
        req_in = '{wr, be, a, d};
        req_valid_in = 1'b1;
        if (!shadow.exists(a)) shadow[a] = 16'h0000;
        if (wr && be[0]) shadow[a][7:0] = d[7:0];
        if (wr && be[1]) shadow[a][15:8] = d[15:8];
        e.rdata = shadow[a] & {{8{be[1]}}, {8{be[0]}}};
        e.err = (a == err_addr);
        if (!wr) exp_q.push_back(e);
        @(negedge clk_in);
        req_valid_in = 1'b0;
    endtask
    always @(negedge clk_in) if (rst_n_in && rsp_valid_out === 1'b1) begin
        if (exp_q.size() == 0) bad("unexpected read result");
        else check_rsp(exp_q.pop_front());
    end
    initial begin
        #20000;
        fail_count++;
        complete_run();
    end
    initial begin
        rst_n_in = 1'b0;
        req_valid_in = 1'b0;
        retain_req_in = 1'b0;
        req_in = '0;
        delay_ns = 5'd15;
        err_addr = 18'h0_0000;
        fail_count = 0;
        total_checks = 0;
        void'($urandom(32'hfb49));
        repeat (20) @(negedge clk_in);
        rst_n_in = 1'b1;
        err_addr = 18'($urandom);
        for (int p = 0; p < 2; p++) begin
            delay_ns = (p == 0) ? 5'd15 : 5'd1;
            for (int i = 0; i < 12; i++) begin
                adr[i] = (i == 0) ? err_addr : 18'($urandom);
                access(1'b1, 2'(i % 3 + 1), adr[i], 16'($urandom));
            end
            for (int i = 0; i < 12; i++) access(1'b0, 2'((i + p) % 3 + 1), adr[i], 16'h0000);
            access(1'b0, 2'b11, err_addr, 16'h0000);
        end
        do begin
            @(negedge clk_in);
        end while (req_ready_out !== 1'b1);
        req_in = '{1'b0, 2'b00, err_addr, 16'h0000};
        req_valid_in = 1'b1;
        repeat (3) @(negedge clk_in);
        req_valid_in = 1'b0;
        check_bit(req_ready_out, 1'b1, "zero lanes request taken");
        check_bit(mem_ctl_out.chip_sel_n, 1'b1, "memory selected without lanes");
        retain_req_in = 1'b1;
        repeat (4) @(negedge clk_in);
        check_bit(retained_out, 1'b1, "retention not entered");
        check_bit(mem_ctl_out.chip_sel_n, 1'b1, "memory selected in retention");
        retain_req_in = 1'b0;
        @(negedge clk_in);
        check_bit(req_ready_out, 1'b0, "recovery too short");
        access(1'b0, 2'b11, adr[5], 16'h0000);
        repeat (10) @(negedge clk_in);
        check_bit(exp_q.size() == 0, 1'b1, "read result missing");
        complete_run();
    end
endmodule
